// file: design/tsp_cfg.svh
// timing and framing constants of the serial stream block
`ifndef TSP_CFG_SVH
`define TSP_CFG_SVH

`define TSP_MCLK_NS        5
`define TSP_SLOTS          32
`define TSP_BITS_PER_SLOT  8
`define TSP_SLOT_W         5
`define TSP_CNT_W          8
`define TSP_NIB_W          4
`define TSP_SYNC_W         5
// bit positions inside the synchronised pin vector
`define TSP_PIN_BCLK       0
`define TSP_PIN_FSYNC_N    1
`define TSP_PIN_RESET_N    2
`define TSP_PIN_PCM_IN     3
`define TSP_PIN_SIG_IN     4
// slot bit at which the next slot's data is requested
`define TSP_REQ_BIT        3'h1
`define TSP_LAST_BIT       3'h7
// least low time of the device reset pin
`define TSP_RESET_MIN_NS   1000
`define TSP_RESET_MIN_CYC  ((`TSP_RESET_MIN_NS + `TSP_MCLK_NS - 1) / `TSP_MCLK_NS)

`endif

// file: design/tsp_core.sv
// serial pcm and signaling stream engine facing the backplane switch
`timescale 1ns/1ps
`include "tsp_cfg.svh"

// Operation
// - signaling status output carries received signaling nibbles, one per slot.
// - nibble_select high drives upper nibble, tristates lower nibble.
// - nibble_select low drives lower nibble, tristates upper nibble.
// - with signaling_source_select high, signaling control input is ignored entirely.
// - control input nibble taken upper or lower half per nibble_select.
// - pcm data output carries received line channel bytes each frame.
// - device held in reset while reset_n low, runs when high.
module tsp_core (
  input  wire logic              mclk,
  input  wire logic              reset,
  input  wire logic              reset_n,
  input  wire logic              bit_clk,
  input  wire logic              frame_sync_n,
  input  wire logic              pcm_data_in,
  input  wire logic              signaling_control_in,
  input  wire logic              nibble_select,
  input  wire logic              signaling_source_select,
  input  wire tsp_pkg::tsp_rx_t  rx_slot,
  output tsp_pkg::tsp_req_t      slot_req,
  output tsp_pkg::tsp_tx_t       tx_slot,
  output logic                   pcm_data_out,
  output logic                   pcm_data_out_oe,
  output logic                   signaling_status_out,
  output logic                   signaling_status_out_oe,
  output logic                   in_reset
);

  // ****************************************
  // pin synchronisation
  // ****************************************
  logic [`TSP_SYNC_W-1:0] pin_vec;
  logic [`TSP_SYNC_W-1:0] pin_lvl;
  logic [`TSP_SYNC_W-1:0] pin_rise;
  logic [`TSP_SYNC_W-1:0] pin_fall;

  assign pin_vec = {signaling_control_in, pcm_data_in, reset_n, frame_sync_n, bit_clk};

  tsp_sync #(
    .W (`TSP_SYNC_W)
  ) u_sync (
    .mclk  (mclk),
    .reset (reset),
    .pin   (pin_vec),
    .level (pin_lvl),
    .rise  (pin_rise),
    .fall  (pin_fall)
  );

  logic bclk_rise;
  logic bclk_fall;
  logic fsync_n_s;
  logic pcm_in_s;
  logic sig_in_s;
  logic dev_rst;

  assign bclk_rise = pin_rise[`TSP_PIN_BCLK];
  assign bclk_fall = pin_fall[`TSP_PIN_BCLK];
  assign fsync_n_s = pin_lvl[`TSP_PIN_FSYNC_N];
  assign pcm_in_s  = pin_lvl[`TSP_PIN_PCM_IN];
  assign sig_in_s  = pin_lvl[`TSP_PIN_SIG_IN];
  assign dev_rst   = reset | ~pin_lvl[`TSP_PIN_RESET_N];

  // ****************************************
  // stream state
  // ****************************************
  tsp_pkg::tsp_state_t r;
  tsp_pkg::tsp_state_t n;

  always_comb begin
    logic [2:0] bit_idx;
    logic [7:0] sig_byte;
    bit_idx     = 3'h0;
    sig_byte    = 8'h00;
    n           = r;
    n.req.valid = 1'b0;
    n.tx.valid  = 1'b0;

    // user data is taken in the same cycle the request is high
    if (r.req.valid) begin
      n.hold_pcm = rx_slot.pcm;
      n.hold_sig = rx_slot.sig;
    end

    // ****************************************
    // output side: bits change on falling edges
    // ****************************************
    if (bclk_fall) begin
      if (!fsync_n_s) begin
        n.framed  = 1'b1;
        n.bit_cnt = '0;
      end else begin
        n.bit_cnt = r.bit_cnt + 8'h01;
      end
      bit_idx = n.bit_cnt[2:0];
      if (n.framed) begin
        if (bit_idx == 3'h0) begin
          n.out_pcm = r.hold_pcm;
          n.out_sig = r.hold_sig;
        end else begin
          n.out_pcm = {r.out_pcm[6:0], 1'b0};
        end
        n.pcm_q  = n.out_pcm[7];
        n.sig_q  = n.out_sig[2'h3 - bit_idx[1:0]];
        // first half of slot is the upper nibble
        n.sig_oe = bit_idx[2] ^ nibble_select;
        if (bit_idx == `TSP_REQ_BIT) begin
          n.req.valid = 1'b1;
          n.req.slot  = n.bit_cnt[7:3] + 5'h01;
        end
      end
    end

    // ****************************************
    // input side: bits sampled on rising edges
    // ****************************************
    if (bclk_rise && r.framed) begin
      n.in_pcm = {r.in_pcm[5:0], pcm_in_s};
      n.in_sig = {r.in_sig[5:0], sig_in_s};
      if (r.bit_cnt[2:0] == `TSP_LAST_BIT) begin
        sig_byte     = {r.in_sig, sig_in_s};
        n.tx.valid   = 1'b1;
        n.tx.slot    = r.bit_cnt[7:3];
        n.tx.pcm     = {r.in_pcm, pcm_in_s};
        n.tx.sig     = nibble_select ? sig_byte[7:4] : sig_byte[3:0];
        n.tx.sig_valid = ~signaling_source_select;
        if (signaling_source_select) begin
          n.tx.sig = '0;
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (dev_rst) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign slot_req                = r.req;
  assign tx_slot                 = r.tx;
  assign pcm_data_out            = r.pcm_q;
  assign pcm_data_out_oe         = r.framed;
  assign signaling_status_out    = r.sig_q;
  assign signaling_status_out_oe = r.framed & r.sig_oe;
  assign in_reset                = dev_rst;

endmodule // tsp_core

// file: design/tsp_pkg.sv
// types shared by the serial stream block and its user side
package tsp_pkg;

  typedef struct packed {
    logic       valid;
    logic [4:0] slot;
  } tsp_req_t;

  typedef struct packed {
    logic [7:0] pcm;
    logic [3:0] sig;
  } tsp_rx_t;

  typedef struct packed {
    logic       valid;
    logic [4:0] slot;
    logic [7:0] pcm;
    logic [3:0] sig;
    logic       sig_valid;
  } tsp_tx_t;

  typedef struct packed {
    logic       framed;
    logic [7:0] bit_cnt;
    logic [7:0] out_pcm;
    logic [3:0] out_sig;
    logic [7:0] hold_pcm;
    logic [3:0] hold_sig;
    logic [6:0] in_pcm;
    logic [6:0] in_sig;
    logic       pcm_q;
    logic       sig_q;
    logic       sig_oe;
    tsp_req_t   req;
    tsp_tx_t    tx;
  } tsp_state_t;

endpackage

// file: design/tsp_sync.sv
// two flip-flop synchroniser with edge detection for pin inputs
`timescale 1ns/1ps

module tsp_sync #(
  parameter int W = 5
) (
  input  wire logic         mclk,
  input  wire logic         reset,
  input  wire logic [W-1:0] pin,
  output logic      [W-1:0] level,
  output logic      [W-1:0] rise,
  output logic      [W-1:0] fall
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
  } tsp_sync_st_t;

  tsp_sync_st_t r;
  tsp_sync_st_t n;

  always_comb begin
    n    = r;
    n.s1 = pin;
    n.s2 = r.s1;
    n.s3 = r.s2;
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  // edges look only at the second and third stages
  for (genvar i = 0; i < W; i++) begin : g_edge
    assign level[i] = r.s2[i];
    assign rise[i]  = r.s2[i] & ~r.s3[i];
    assign fall[i]  = ~r.s2[i] & r.s3[i];
  end

endmodule // tsp_sync

// file: verif/tb_tsp_core.sv
// self-checking bench of the serial stream engine
`timescale 1ns/1ps
module tb_tsp_core;
  logic              mclk = 1'b0, reset = 1'b1, reset_n = 1'b1, chk = 1'b0;
  logic              nibble_select = 1'b0, signaling_source_select = 1'b0;
  logic              bit_clk, frame_sync_n, pcm_data_in, signaling_control_in;
  logic              pcm_data_out, pcm_data_out_oe, signaling_status_out;
  logic              signaling_status_out_oe, in_reset;
  logic [7:0]        seed = 8'h3c;
  tsp_pkg::tsp_rx_t  rx_slot = '0;
  tsp_pkg::tsp_rx_t  sent [32];
  tsp_pkg::tsp_req_t slot_req;
  tsp_pkg::tsp_tx_t  tx_slot;
  int                err_count = 0, checks_done = 0;
  wire [4:0]         cs = u_bus.cnt[7:3];
  wire [2:0]         ci = u_bus.cnt[2:0];
  wire               hi = nibble_select ? !ci[2] : ci[2];
  tsp_core u_dut (.*);
  tsp_bus_model u_bus (.*);
  always #2.5 mclk = ~mclk;
  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  function automatic logic [3:0] exp_sig(input logic [4:0] s);
    return signaling_source_select ? 4'h0 : nibble_select ? ~s[3:0] : s[3:0];
  endfunction
  task automatic chk_bit(input logic g, input logic e);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %0t bit got %b exp %b", $time, g, e);
    end
  endtask
  task automatic chk_val(input logic [7:0] g, input logic [7:0] e);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %0t value got %h exp %h", $time, g, e);
    end
  endtask
  task automatic stop_test;
    $display("errors %0d checks %0d", err_count, checks_done);
    if (err_count == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // slot data stands ready while the request is high, then moves on
  always @(posedge mclk) if (slot_req.valid === 1'b1) begin
    seed <= lfsr(seed);
    rx_slot <= {seed, seed[6:3]};
    sent[slot_req.slot] <= rx_slot;
  end
  always @(negedge mclk) if (chk && tx_slot.valid === 1'b1) begin
    chk_val(tx_slot.pcm, {tx_slot.slot, 3'h5});
    chk_val({4'h0, tx_slot.sig}, {4'h0, exp_sig(tx_slot.slot)});
    chk_bit(tx_slot.sig_valid, ~signaling_source_select);
  end
  always @(posedge bit_clk) if (chk) begin
    chk_bit(pcm_data_out_oe, 1'b1);
    chk_bit(pcm_data_out, sent[cs].pcm[~ci]);
    chk_bit(signaling_status_out_oe, hi);
    if (hi) chk_bit(signaling_status_out, sent[cs].sig[~ci[1:0]]);
  end
  initial begin
    repeat (10) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk) reset_n <= 1'b0;
    repeat (220) @(posedge mclk);
    chk_bit(in_reset, 1'b1);
    reset_n <= 1'b1;
    for (int m = 0; m < 4; m++) begin
      @(posedge mclk) reset <= 1'b1;
      {signaling_source_select, nibble_select} <= m[1:0];
      repeat (10) @(posedge mclk);
      reset <= 1'b0;
      repeat (8400) @(posedge mclk);
      chk <= 1'b1;
      repeat (4200) @(posedge mclk);
      chk <= 1'b0;
    end
    stop_test;
  end
  initial begin
    #400000;
    err_count++;
    stop_test;
  end
endmodule // tb_tsp_core

// file: verif/tsp_bus_model.sv
// backplane switch model driving the serial link
`timescale 1ns/1ps
module tsp_bus_model (
  output logic bit_clk,
  output logic frame_sync_n,
  output logic pcm_data_in,
  output logic signaling_control_in
);
  logic [7:0] cnt = 8'hff;
  logic [7:0] pb;
  logic [7:0] sb;
  // bit clock runs free on this backplane
  initial begin
    {bit_clk, frame_sync_n, pcm_data_in, signaling_control_in} = 4'h5;
    forever begin
      #40 bit_clk = 1'b1;
      frame_sync_n = (cnt != 8'hff);
      #40 bit_clk = 1'b0;
      cnt = cnt + 8'h01;
      pb = {cnt[7:3], 3'h5};
      sb = {~cnt[6:3], cnt[6:3]};
      pcm_data_in = pb[~cnt[2:0]];
      signaling_control_in = sb[~cnt[2:0]];
    end
  end
endmodule // tsp_bus_model

// file: verif/tsp_core_monitor.sv
// port assertions of the serial stream engine
`timescale 1ns/1ps
module tsp_core_monitor (
  input wire logic              mclk,
  input wire logic              reset,
  input wire logic              reset_n,
  input wire logic              nibble_select,
  input wire logic              signaling_source_select,
  input wire tsp_pkg::tsp_req_t slot_req,
  input wire tsp_pkg::tsp_tx_t  tx_slot,
  input wire logic              pcm_data_out_oe,
  input wire logic              signaling_status_out_oe,
  input wire logic              in_reset
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (in_reset);
  property p_rst_out;
    disable iff (reset) in_reset |=> !pcm_data_out_oe && !signaling_status_out_oe
      && !slot_req.valid && !tx_slot.valid;
  endproperty
  a_rst_out: assert property (p_rst_out) else $error("outputs active in reset");
  property p_rst_in; disable iff (reset) !reset_n [*3] |-> in_reset; endproperty
  a_rst_in: assert property (p_rst_in) else $error("reset pin ignored");
  property p_req_gap; slot_req.valid |=> !slot_req.valid [*8]; endproperty
  a_req_gap: assert property (p_req_gap) else $error("slot request too long");
  property p_tx_stab;
    !tx_slot.valid && !$past(in_reset)
      |-> $stable({tx_slot.slot, tx_slot.pcm, tx_slot.sig, tx_slot.sig_valid});
  endproperty
  a_tx_stab: assert property (p_tx_stab) else $error("tx fields moved");
  property p_ssel;
    tx_slot.valid && signaling_source_select && $past(signaling_source_select)
      |-> !tx_slot.sig_valid && tx_slot.sig == 4'h0;
  endproperty
  a_ssel: assert property (p_ssel) else $error("control input not ignored");
  property p_upper;
    slot_req.valid && nibble_select |-> ##[47:49] $fell(signaling_status_out_oe);
  endproperty
  a_upper: assert property (p_upper) else $error("upper nibble misplaced");
  property p_lower;
    slot_req.valid && !nibble_select |-> ##[47:49] $rose(signaling_status_out_oe);
  endproperty
  a_lower: assert property (p_lower) else $error("lower nibble misplaced");
  property p_oe_hold; pcm_data_out_oe |=> pcm_data_out_oe; endproperty
  a_oe_hold: assert property (p_oe_hold) else $error("data output dropped");
  c_req: cover property (slot_req.valid);
  c_sig: cover property (tx_slot.valid && tx_slot.sig_valid);
  c_oe: cover property ($rose(signaling_status_out_oe));
endmodule // tsp_core_monitor
bind tsp_core tsp_core_monitor u_mon (.*);
